// ===== src/vccr_cfg.svh
// constants for the voice codec control register bank
`ifndef VCCR_CFG_SVH
`define VCCR_CFG_SVH

// register addresses carried in the control word
`define VCCR_ADDR_RSVD_LOW 3'h0
`define VCCR_ADDR_GAIN 3'h1
`define VCCR_ADDR_FILT 3'h2
`define VCCR_ADDR_PDC 3'h3
`define VCCR_ADDR_FAST 3'h4
`define VCCR_ADDR_SLOW 3'h5
`define VCCR_ADDR_RSVD_HIGH 3'h6
`define VCCR_NUM_REGS 5

// reset values
`define VCCR_RST_GAIN 8'h46
`define VCCR_RST_FILT 8'h11
`define VCCR_RST_PDC 8'h00
`define VCCR_RST_FAST 8'hF7
`define VCCR_RST_SLOW 8'h42

// implemented-bit masks, unused bits read as zero
`define VCCR_MASK_GAIN 8'hFF
`define VCCR_MASK_FILT 8'hFF
`define VCCR_MASK_PDC 8'hFF
`define VCCR_MASK_FAST 8'hFF
`define VCCR_MASK_SLOW 8'hFF

// gain register fields
`define VCCR_GAIN_READBACK_BIT 7
`define VCCR_GAIN_CODE_MSB 6
`define VCCR_GAIN_CODE_LSB 0

// filter / shift register fields
`define VCCR_FILT_WEAK_BIT 7
`define VCCR_FILT_HPF_MSB 6
`define VCCR_FILT_HPF_LSB 5
`define VCCR_FILT_SHIFT_MSB 4
`define VCCR_FILT_SHIFT_LSB 2
`define VCCR_FILT_DAC_MSB 1
`define VCCR_FILT_DAC_LSB 0
`define VCCR_SHIFT_MAX 3'h5

// power-down control register fields
`define VCCR_PDC_ADAPT_BIT 7
`define VCCR_PDC_BRIDGE_EN_BIT 6
`define VCCR_PDC_BRIDGE_DRV_BIT 5
`define VCCR_PDC_HYST_BIT 4
`define VCCR_PDC_MODE_MSB 3
`define VCCR_PDC_MODE_LSB 2
`define VCCR_PDC_MIC_PD_BIT 1
`define VCCR_PDC_FRONT_PD_BIT 0

// rate register fields
`define VCCR_RATE_ATTACK_MSB 7
`define VCCR_RATE_ATTACK_LSB 4
`define VCCR_RATE_RELEASE_MSB 3
`define VCCR_RATE_RELEASE_LSB 0

// timing
`define VCCR_CLK_KHZ 40000
`define VCCR_HYST_LONG_MS 50
`define VCCR_HYST_SHORT_MS 25

`endif

// ===== src/vccr_pkg.sv
// types shared by the voice codec control register bank
package vccr_pkg;

  typedef enum logic [1:0] {
    VCCR_HPF_NORMAL,
    VCCR_HPF_BYPASS,
    VCCR_HPF_CORNER_100HZ,
    VCCR_HPF_UNUSED
  } vccr_hpf_e;

  typedef enum logic [1:0] {
    VCCR_DAC_OFF,
    VCCR_DAC_SHIFTED_16,
    VCCR_DAC_DIRECT_20,
    VCCR_DAC_LOOPBACK
  } vccr_dac_e;

  typedef enum logic [1:0] {
    VCCR_GAIN_AUTO_DUAL,
    VCCR_GAIN_AUTO_SINGLE,
    VCCR_GAIN_FIXED_SINGLE,
    VCCR_GAIN_FIXED_IMMEDIATE
  } vccr_gain_mode_e;

  typedef logic [7:0] vccr_byte_t;

  typedef struct packed {
    logic rw;
    logic [2:0] addr;
    vccr_byte_t data;
  } vccr_ctrl_word_s;

  typedef struct packed {
    logic gain_readback_select;
    logic [6:0] gain_code;
    logic weak_io_drive_enable;
    vccr_hpf_e highpass_control;
    logic [2:0] shift_amount;
    vccr_dac_e dac_mode;
    logic dac_power_down;
    logic adaptive_quantization;
    logic bridge_output_enable;
    logic bridge_drive_strength;
    logic hysteresis_timeout_select;
    vccr_gain_mode_e gain_mode_select;
    logic mic_supply_power_down;
    logic input_chain_power_down;
    logic [3:0] fast_attack;
    logic [3:0] fast_release;
    logic slow_rate_active;
    logic [3:0] slow_attack;
    logic [3:0] slow_release;
  } vccr_fields_s;

endpackage

// ===== src/vccr_shifter.sv
// left shifter from the 16-bit host or adc word to the 20-bit dac input
`timescale 1ns/1ps
`include "vccr_cfg.svh"

module vccr_shifter
  import vccr_pkg::*;
(
  input wire logic [15:0] din,
  input wire logic [2:0] shift_code,
  output logic [19:0] dout
);

  localparam logic signed [15:0] LIM_POS = 16'h3FFF;
  localparam logic signed [15:0] LIM_NEG = 16'hC000;

  logic signed [15:0] clamped;
  logic signed [19:0] wide;

  always_comb begin
    clamped = $signed(din);
    wide = {{4{din[15]}}, din};
    dout = 20'h00000;
    // codes above five collapse onto five
    if (shift_code >= `VCCR_SHIFT_MAX) begin
      // clamp to 15 bits first so the five-bit shift cannot wrap
      if ($signed(din) > LIM_POS) begin
        clamped = LIM_POS;
      end else if ($signed(din) < LIM_NEG) begin
        clamped = LIM_NEG;
      end
      dout = {clamped[14:0], 5'h00};
    end else begin
      dout = 20'(wide <<< shift_code);
    end
  end

endmodule

// ===== src/vccr_regbank.sv
// control register bank of the voice-band codec, with dac input selection
//
// What this block does
// - decode addresses one to five, rest reserved
// - gain bit7 selects stored or applied readback
// - gain code, half-dB steps, -1 to +40
// - gain register resets to 0x46
// - filter bit7 gives half-strength io drive
// - highpass field selects normal, bypass, 100 Hz
// - shift field shifts the 16-bit host or adc word zero to five
// - dac mode: off, shifted, direct, loopback
// - power-down bit7 picks adaptive quantization
// - power-down bit6 enables bridge, off at reset
// - power-down bit5 picks bridge drive strength
// - power-down bit4 picks 50 or 25 ms
// - power-down bits3:2 select compressor gain mode
// - bit0 front end down, bit1 mic supply
// - fast register upper nibble is attack rate
// - fast lower nibble release, reset 0xF7
// - 12-bit control word, address zero idles
// - unused bits always read back zero
// - slow rates act only in dual mode
// - five-bit shift saturates to 15 bits
`timescale 1ns/1ps
`include "vccr_cfg.svh"

module vccr_regbank
  import vccr_pkg::*;
#(
  parameter int HYST_LONG_CYCLES = `VCCR_HYST_LONG_MS * `VCCR_CLK_KHZ,
  parameter int HYST_SHORT_CYCLES = `VCCR_HYST_SHORT_MS * `VCCR_CLK_KHZ
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic ctrl_valid,
  input wire vccr_ctrl_word_s ctrl_word,
  input wire logic [6:0] applied_gain,
  input wire logic audio_valid,
  input wire logic [19:0] host_audio,
  input wire logic [15:0] adc_word,
  output logic rd_valid,
  output vccr_byte_t rd_data,
  output vccr_fields_s fields,
  output logic dac_valid,
  output logic [19:0] dac_word,
  output logic [20:0] hyst_timeout_cycles
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [`VCCR_NUM_REGS-1:0][7:0] regs;
    vccr_byte_t rd_data;
    logic rd_valid;
    logic [19:0] dac_word;
    logic dac_valid;
    logic [20:0] hyst_cycles;
  } vccr_state_s;

  vccr_state_s state_ff;
  vccr_state_s nxt_state;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // true for the five user registers only
  function automatic logic vccr_is_user(input logic [2:0] addr);
    vccr_is_user = (addr >= `VCCR_ADDR_GAIN) && (addr <= `VCCR_ADDR_SLOW);
  endfunction

  function automatic logic [2:0] vccr_index(input logic [2:0] addr);
    vccr_index = 3'(addr - `VCCR_ADDR_GAIN);
  endfunction

  function automatic vccr_byte_t vccr_mask(input logic [2:0] addr);
    case (addr)
      `VCCR_ADDR_GAIN: vccr_mask = `VCCR_MASK_GAIN;
      `VCCR_ADDR_FILT: vccr_mask = `VCCR_MASK_FILT;
      `VCCR_ADDR_PDC: vccr_mask = `VCCR_MASK_PDC;
      `VCCR_ADDR_FAST: vccr_mask = `VCCR_MASK_FAST;
      `VCCR_ADDR_SLOW: vccr_mask = `VCCR_MASK_SLOW;
      default: vccr_mask = 8'h00;
    endcase
  endfunction

  // ------------------------------------------------------------
  // register defaults
  // ------------------------------------------------------------
  localparam logic [`VCCR_NUM_REGS-1:0][7:0] REG_DEFAULTS = {
    `VCCR_RST_SLOW,
    `VCCR_RST_FAST,
    `VCCR_RST_PDC,
    `VCCR_RST_FILT,
    `VCCR_RST_GAIN
  };

  localparam logic [20:0] HYST_LONG = 21'(HYST_LONG_CYCLES);
  localparam logic [20:0] HYST_SHORT = 21'(HYST_SHORT_CYCLES);

  // ------------------------------------------------------------
  // field views of the stored registers
  // ------------------------------------------------------------
  vccr_byte_t gain_reg;
  vccr_byte_t filt_reg;
  vccr_byte_t pdc_reg;
  vccr_byte_t fast_reg;
  vccr_byte_t slow_reg;
  logic [2:0] shift_code;
  logic [19:0] shifted;
  logic [15:0] shift_src;
  vccr_dac_e dac_mode;
  vccr_gain_mode_e gain_mode;

  assign gain_reg = state_ff.regs[vccr_index(`VCCR_ADDR_GAIN)];
  assign filt_reg = state_ff.regs[vccr_index(`VCCR_ADDR_FILT)];
  assign pdc_reg = state_ff.regs[vccr_index(`VCCR_ADDR_PDC)];
  assign fast_reg = state_ff.regs[vccr_index(`VCCR_ADDR_FAST)];
  assign slow_reg = state_ff.regs[vccr_index(`VCCR_ADDR_SLOW)];
  assign shift_code = filt_reg[`VCCR_FILT_SHIFT_MSB:`VCCR_FILT_SHIFT_LSB];
  assign dac_mode = vccr_dac_e'(filt_reg[`VCCR_FILT_DAC_MSB:`VCCR_FILT_DAC_LSB]);
  assign gain_mode = vccr_gain_mode_e'(pdc_reg[`VCCR_PDC_MODE_MSB:`VCCR_PDC_MODE_LSB]);

  // loopback feeds the local adc word, otherwise the host's 16-bit word
  assign shift_src = (dac_mode == VCCR_DAC_LOOPBACK) ? adc_word : host_audio[19:4];

  vccr_shifter u_shifter (
    .din(shift_src),
    .shift_code(shift_code),
    .dout(shifted)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rd_valid = 1'b0;
    nxt_state.dac_valid = 1'b0;

    // address zero carries no control action
    if (ctrl_valid && (ctrl_word.addr != `VCCR_ADDR_RSVD_LOW)) begin
      if (ctrl_word.rw) begin
        // reserved addresses are dropped; the controller avoids them
        for (int i = 0; i < `VCCR_NUM_REGS; i++) begin
          if (vccr_is_user(ctrl_word.addr) && (vccr_index(ctrl_word.addr) == 3'(i))) begin
            nxt_state.regs[i] = ctrl_word.data & vccr_mask(ctrl_word.addr);
          end
        end
      end else begin
        nxt_state.rd_valid = 1'b1;
        case (ctrl_word.addr)
          `VCCR_ADDR_GAIN: begin
            // readback select chooses stored code or live compressor gain
            if (gain_reg[`VCCR_GAIN_READBACK_BIT]) begin
              nxt_state.rd_data = {gain_reg[`VCCR_GAIN_READBACK_BIT], applied_gain};
            end else begin
              nxt_state.rd_data = gain_reg;
            end
          end
          `VCCR_ADDR_FILT: begin
            nxt_state.rd_data = filt_reg & `VCCR_MASK_FILT;
          end
          `VCCR_ADDR_PDC: begin
            nxt_state.rd_data = pdc_reg & `VCCR_MASK_PDC;
          end
          `VCCR_ADDR_FAST: begin
            nxt_state.rd_data = fast_reg & `VCCR_MASK_FAST;
          end
          `VCCR_ADDR_SLOW: begin
            nxt_state.rd_data = slow_reg & `VCCR_MASK_SLOW;
          end
          default: begin
            // reserved space answers zero
            nxt_state.rd_data = 8'h00;
          end
        endcase
      end
    end

    // ----------------------------------------------------------
    // dac input path, one word per audio strobe
    // ----------------------------------------------------------
    if (audio_valid) begin
      nxt_state.dac_valid = 1'b1;
      case (dac_mode)
        VCCR_DAC_OFF: begin
          // powered-down dac gets silence, avoids stale data on wake
          nxt_state.dac_word = 20'h00000;
        end
        VCCR_DAC_SHIFTED_16: begin
          nxt_state.dac_word = shifted;
        end
        VCCR_DAC_DIRECT_20: begin
          nxt_state.dac_word = host_audio;
        end
        VCCR_DAC_LOOPBACK: begin
          nxt_state.dac_word = shifted;
        end
        default: begin
          nxt_state.dac_word = 20'h00000;
        end
      endcase
    end

    // compressor hysteresis timeout in clock cycles
    if (pdc_reg[`VCCR_PDC_HYST_BIT]) begin
      nxt_state.hyst_cycles = HYST_SHORT;
    end else begin
      nxt_state.hyst_cycles = HYST_LONG;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    // either reset source restores every default
    if (rst || por_rst) begin
      state_ff.regs <= REG_DEFAULTS;
      state_ff.rd_data <= 8'h00;
      state_ff.rd_valid <= 1'b0;
      state_ff.dac_word <= 20'h00000;
      state_ff.dac_valid <= 1'b0;
      state_ff.hyst_cycles <= HYST_LONG;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rd_valid = state_ff.rd_valid;
  assign rd_data = state_ff.rd_data;
  assign dac_valid = state_ff.dac_valid;
  assign dac_word = state_ff.dac_word;
  assign hyst_timeout_cycles = state_ff.hyst_cycles;

  always_comb begin
    fields.gain_readback_select = gain_reg[`VCCR_GAIN_READBACK_BIT];
    // code to dB mapping is in the compressor
    fields.gain_code = gain_reg[`VCCR_GAIN_CODE_MSB:`VCCR_GAIN_CODE_LSB];
    fields.weak_io_drive_enable = filt_reg[`VCCR_FILT_WEAK_BIT];
    fields.highpass_control =
      vccr_hpf_e'(filt_reg[`VCCR_FILT_HPF_MSB:`VCCR_FILT_HPF_LSB]);
    // effective shift, 11x reported as five
    fields.shift_amount = (shift_code > `VCCR_SHIFT_MAX) ? `VCCR_SHIFT_MAX : shift_code;
    fields.dac_mode = dac_mode;
    fields.dac_power_down = (dac_mode == VCCR_DAC_OFF);
    fields.adaptive_quantization = pdc_reg[`VCCR_PDC_ADAPT_BIT];
    fields.bridge_output_enable = pdc_reg[`VCCR_PDC_BRIDGE_EN_BIT];
    fields.bridge_drive_strength = pdc_reg[`VCCR_PDC_BRIDGE_DRV_BIT];
    fields.hysteresis_timeout_select = pdc_reg[`VCCR_PDC_HYST_BIT];
    fields.gain_mode_select = gain_mode;
    fields.mic_supply_power_down = pdc_reg[`VCCR_PDC_MIC_PD_BIT];
    fields.input_chain_power_down = pdc_reg[`VCCR_PDC_FRONT_PD_BIT];
    fields.fast_attack = fast_reg[`VCCR_RATE_ATTACK_MSB:`VCCR_RATE_ATTACK_LSB];
    fields.fast_release = fast_reg[`VCCR_RATE_RELEASE_MSB:`VCCR_RATE_RELEASE_LSB];
    // slow rates are masked out unless dual rate is selected
    fields.slow_rate_active = (gain_mode == VCCR_GAIN_AUTO_DUAL);
    if (gain_mode == VCCR_GAIN_AUTO_DUAL) begin
      fields.slow_attack = slow_reg[`VCCR_RATE_ATTACK_MSB:`VCCR_RATE_ATTACK_LSB];
      fields.slow_release = slow_reg[`VCCR_RATE_RELEASE_MSB:`VCCR_RATE_RELEASE_LSB];
    end else begin
      fields.slow_attack = 4'h0;
      fields.slow_release = 4'h0;
    end
  end

endmodule

// ===== sim/vccr_regbank_asserts.sv
// assertion checker for the control register bank
`timescale 1ns/1ps
module vccr_regbank_chk
  import vccr_pkg::*;
#(
  parameter int HYST_LONG_CYCLES = 50,
  parameter int HYST_SHORT_CYCLES = 25
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic ctrl_valid,
  input wire vccr_ctrl_word_s ctrl_word,
  input wire logic [6:0] applied_gain,
  input wire logic audio_valid,
  input wire logic [19:0] host_audio,
  input wire logic [15:0] adc_word,
  input wire logic rd_valid,
  input wire vccr_byte_t rd_data,
  input wire vccr_fields_s fields,
  input wire logic dac_valid,
  input wire logic [19:0] dac_word,
  input wire logic [20:0] hyst_timeout_cycles
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst || por_rst);
  logic rd_req;
  logic wr_req;
  assign rd_req = ctrl_valid && !ctrl_word.rw;
  assign wr_req = ctrl_valid && ctrl_word.rw;

  rd_answer_a: assert property (rd_req && ctrl_word.addr != 3'h0
    |=> rd_valid) else $error("read not answered");
  rsvd_read_a: assert property (rd_req && ctrl_word.addr > 3'h5
    |=> rd_data == 8'h00) else $error("reserved read not zero");
  gain_write_a: assert property (wr_req && ctrl_word.addr == 3'h1
    |=> {fields.gain_readback_select, fields.gain_code} == $past(ctrl_word.data))
    else $error("gain field mismatch");
  gain_readback_a: assert property (rd_req && ctrl_word.addr == 3'h1
    && fields.gain_readback_select |=> rd_data == {1'b1, $past(applied_gain)})
    else $error("applied gain readback wrong");
  pdc_write_a: assert property (wr_req && ctrl_word.addr == 3'h3
    |=> {fields.adaptive_quantization, fields.bridge_output_enable,
    fields.bridge_drive_strength} == $past(ctrl_word.data[7:5]))
    else $error("power-down fields wrong");
  dac_pulse_a: assert property (dac_valid == $past(audio_valid))
    else $error("dac pulse timing wrong");
  dac_off_a: assert property (audio_valid && fields.dac_mode == VCCR_DAC_OFF
    |=> dac_word == 20'h00000) else $error("dac off word not zero");
  direct_mode_a: assert property (audio_valid && fields.dac_mode == VCCR_DAC_DIRECT_20
    |=> dac_word == $past(host_audio)) else $error("direct word wrong");
  slow_gate_a: assert property (fields.gain_mode_select != VCCR_GAIN_AUTO_DUAL
    |-> !fields.slow_rate_active && {fields.slow_attack, fields.slow_release} == 8'h00)
    else $error("slow rates active outside dual mode");
  hyst_sel_a: assert property (fields.hysteresis_timeout_select
    |=> hyst_timeout_cycles == 21'(HYST_SHORT_CYCLES)) else $error("short timeout wrong");
endmodule

bind vccr_regbank vccr_regbank_chk #(.HYST_LONG_CYCLES(HYST_LONG_CYCLES),
  .HYST_SHORT_CYCLES(HYST_SHORT_CYCLES)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .por_rst(por_rst), .ctrl_valid(ctrl_valid), .ctrl_word(ctrl_word),
  .applied_gain(applied_gain), .audio_valid(audio_valid), .host_audio(host_audio),
  .adc_word(adc_word), .rd_valid(rd_valid), .rd_data(rd_data), .fields(fields),
  .dac_valid(dac_valid), .dac_word(dac_word), .hyst_timeout_cycles(hyst_timeout_cycles));

// ===== sim/vccr_host_model.sv
// controller model issuing control words and reporting applied gain
`timescale 1ns/1ps
module vccr_host_model
  import vccr_pkg::*;
(
  input wire logic clk_sys,
  output logic ctrl_valid,
  output vccr_ctrl_word_s ctrl_word,
  output logic [6:0] applied_gain
);
  logic [6:0] gain_now = 7'h00;
  int gap = 0;
  initial begin
    ctrl_valid = 1'b0;
    ctrl_word = '0;
  end
  assign applied_gain = gain_now;
  // one word per access, none for writes to reserved addresses, gap idle cycles first to act slow
  task automatic access(input logic rw, input logic [2:0] addr, input logic [7:0] data);
    if (rw && (addr == 3'h0 || addr > 3'h5)) return;
    repeat (gap) @(posedge clk_sys);
    @(posedge clk_sys);
    #1 ctrl_valid = 1'b1;
    ctrl_word = {rw, addr, data};
    @(posedge clk_sys);
    #1 ctrl_valid = 1'b0;
    // idle word never repeats the last one
    ctrl_word = ~ctrl_word;
  endtask
endmodule

// ===== sim/tb_vccr_regbank.sv
// self-checking testbench for the control register bank
`timescale 1ns/1ps
module tb_vccr_regbank;
  import vccr_pkg::*;
  logic clk_sys;
  logic rst;
  logic por_rst;
  logic ctrl_valid;
  vccr_ctrl_word_s ctrl_word;
  logic [6:0] applied_gain;
  logic audio_valid;
  logic [19:0] host_audio;
  logic [15:0] adc_word;
  logic rd_valid;
  vccr_byte_t rd_data;
  vccr_fields_s fields;
  logic dac_valid;
  logic [19:0] dac_word;
  logic [20:0] hyst_timeout_cycles;
  int err_count = 0;
  int n_compared = 0;
  logic [7:0] dflt [1:5] = '{8'h46, 8'h11, 8'h00, 8'hF7, 8'h42};

  vccr_host_model u_host (.clk_sys(clk_sys), .ctrl_valid(ctrl_valid),
    .ctrl_word(ctrl_word), .applied_gain(applied_gain));
  vccr_regbank #(.HYST_LONG_CYCLES(50), .HYST_SHORT_CYCLES(25)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .por_rst(por_rst), .ctrl_valid(ctrl_valid),
    .ctrl_word(ctrl_word), .applied_gain(applied_gain), .audio_valid(audio_valid),
    .host_audio(host_audio), .adc_word(adc_word), .rd_valid(rd_valid),
    .rd_data(rd_data), .fields(fields), .dac_valid(dac_valid), .dac_word(dac_word),
    .hyst_timeout_cycles(hyst_timeout_cycles));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    u_host.access(1'b0, a, 8'h00);
    chk(20'(rd_valid), 20'h1);
    chk(20'(rd_data), 20'(exp));
  endtask
  task automatic aud(input logic [19:0] h, input logic [15:0] a, input logic [19:0] exp);
    @(posedge clk_sys);
    #1 audio_valid = 1'b1;
    host_audio = h;
    adc_word = a;
    @(posedge clk_sys);
    #1 audio_valid = 1'b0;
    chk(20'(dac_valid), 20'h1);
    chk(dac_word, exp);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    #(25 * 5000);
    err_count++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    por_rst = 1'b0;
    audio_valid = 1'b0;
    host_audio = 20'h00000;
    adc_word = 16'h0000;
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    for (int a = 1; a <= 5; a++) rd(3'(a), dflt[a]);
    chk(20'(fields.bridge_output_enable), 20'h0);
    rd(3'h6, 8'h00);
    rd(3'h7, 8'h00);
    u_host.access(1'b0, 3'h0, 8'h00);
    chk(20'(rd_valid), 20'h0);
    for (int m = 0; m < 4; m++) begin
      u_host.access(1'b1, 3'h3, {3'b101, 1'b0, 2'(m), 2'b11});
      chk(20'(fields.gain_mode_select), 20'(m));
      chk(20'({fields.adaptive_quantization, fields.bridge_output_enable,
        fields.bridge_drive_strength}), 20'h5);
      chk(20'(fields.slow_attack), (m == 0) ? 20'h4 : 20'h0);
      chk(20'({fields.mic_supply_power_down, fields.input_chain_power_down}), 20'h3);
    end
    u_host.access(1'b1, 3'h4, 8'h3C);
    chk(20'({fields.fast_attack, fields.fast_release}), 20'h3C);
    for (int h = 0; h < 3; h++) begin
      u_host.access(1'b1, 3'h2, {1'b1, 2'(h), 5'h01});
      chk(20'({fields.weak_io_drive_enable, fields.highpass_control}), 20'(4 + h));
    end
    u_host.gap = 2;
    // gain bit7 kept clear here so the read shows stored contents
    for (int a = 1; a <= 5; a++) u_host.access(1'b1, 3'(a), 8'h5A ^ 8'(a));
    u_host.gap = 0;
    for (int a = 1; a <= 5; a++) rd(3'(a), 8'h5A ^ 8'(a));
    u_host.access(1'b1, 3'h1, 8'hC6);
    u_host.gain_now = 7'h52;
    rd(3'h1, 8'hD2);
    u_host.gain_now = 7'h00;
    rd(3'h1, 8'h80);
    u_host.access(1'b1, 3'h1, 8'h52);
    rd(3'h1, 8'h52);
    for (int c = 0; c < 8; c++) begin
      u_host.access(1'b1, 3'h2, {3'b000, 3'(c), 2'b01});
      chk(20'(fields.shift_amount), 20'((c > 5) ? 5 : c));
      aud(20'h00010, 16'hFFFF, 20'h1 << ((c > 5) ? 5 : c));
    end
    u_host.access(1'b1, 3'h2, 8'h17);
    aud(20'hFFFFF, 16'h7FFF, 20'h7FFE0);
    aud(20'hFFFFF, 16'h8000, 20'h80000);
    u_host.access(1'b1, 3'h2, 8'h02);
    aud(20'hABCDE, 16'h1234, 20'hABCDE);
    chk(20'(fields.dac_power_down), 20'h0);
    u_host.access(1'b1, 3'h2, 8'h00);
    chk(20'(fields.dac_power_down), 20'h1);
    aud(20'hABCDE, 16'h1234, 20'h00000);
    u_host.access(1'b1, 3'h3, 8'h10);
    @(posedge clk_sys);
    #1 chk(20'(hyst_timeout_cycles), 20'd25);
    por_rst = 1'b1;
    @(posedge clk_sys);
    #1 por_rst = 1'b0;
    chk(20'(hyst_timeout_cycles), 20'd50);
    for (int a = 1; a <= 5; a++) rd(3'(a), dflt[a]);
    report_and_stop();
  end
endmodule
